// ==== core/dspmc_exec.sv ====
// Execution unit for multiply, stack, data-move, port-in and table ops
// Overview of operation
// - Add-product adds product register to accumulator, one cycle.
// - Load-multiplicand-accumulate loads multiplicand, adds old product.
// - Same, plus copies the operand word to the next address.
// - Multiply: multiplicand times data word into product, one cycle.
// - Immediate multiply: multiplicand times in-word constant to product.
// - Product-transfer replaces accumulator with product, one cycle.
// - Subtract-product subtracts product from accumulator, one cycle.
// - Pop moves top stack entry into accumulator in two cycles.
// - Push places accumulator low word onto stack in two cycles.
// - Data-move copies the data word to the next higher address.
// - Port-input reads selected port into data memory, two cycles.
// - Table-read moves program word into data RAM, three cycles.
// - Table-write moves data word into program memory, three cycles.
module dspmc_exec (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Instruction issue
	input wire dspmc_pkg::dspmc_issue_t issue,
	output logic ready_ff,
	output logic done_ff,
	// Data memory write port
	output dspmc_pkg::dspmc_dwr_t dwr_ff,
	// Program memory port
	input wire logic [dspmc_pkg::DW-1:0] pmem_rdata,
	output dspmc_pkg::dspmc_pmem_t pmem_ff,
	// I/O port read
	input wire logic [dspmc_pkg::DW-1:0] port_rdata,
	output dspmc_pkg::dspmc_port_t port_ff,
	// Visible machine state
	output logic [dspmc_pkg::AW-1:0] acc_ff,
	output logic [dspmc_pkg::DW-1:0] mcand_ff,
	output logic [dspmc_pkg::AW-1:0] prod_ff
);

	//----------------------------------------------------------------
	// State
	//----------------------------------------------------------------
	typedef struct packed {
		dspmc_pkg::dspmc_mcop_t op;
		logic [1:0] cnt;
		logic ready;
		logic done;
		logic [dspmc_pkg::AW-1:0] acc;
		logic [dspmc_pkg::DW-1:0] mcand;
		logic [dspmc_pkg::AW-1:0] prod;
		logic [dspmc_pkg::STK_DEPTH-1:0][dspmc_pkg::DW-1:0] stk;
		logic [dspmc_pkg::DAW-1:0] daddr;
		logic [dspmc_pkg::DW-1:0] operand;
		dspmc_pkg::dspmc_dwr_t dwr;
		dspmc_pkg::dspmc_pmem_t pmem;
		dspmc_pkg::dspmc_port_t port;
	} dspmc_state_t;

	dspmc_state_t st_ff;
	dspmc_state_t nxt_st;
	logic accept;
	logic [dspmc_pkg::DW-1:0] mul_b;
	logic [dspmc_pkg::AW-1:0] mul_p;
	logic [7:0] hi;

	assign accept = issue.valid && st_ff.ready;
	assign hi = issue.instr[15:8];

	// Multiplier operand: immediate constant or addressed data word
	always_comb begin
		if (issue.instr[15:13] == dspmc_pkg::OPC_MULT_IMM) begin
			mul_b = {{(dspmc_pkg::DW-dspmc_pkg::IMM_MSB-1)
				{issue.instr[dspmc_pkg::IMM_MSB]}},
				issue.instr[dspmc_pkg::IMM_MSB:0]};
		end else begin
			mul_b = issue.operand;
		end
	end

	dspmc_mult u_mult (
		.mcand(st_ff.mcand),
		.mplier(mul_b),
		.product(mul_p)
	);

	//----------------------------------------------------------------
	// Next-state logic
	//----------------------------------------------------------------
	// Single-cycle ops act at issue; multi-cycle ops hold ready low
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		nxt_st.dwr.we = 1'b0;
		nxt_st.pmem.re = 1'b0;
		nxt_st.pmem.we = 1'b0;
		nxt_st.port.re = 1'b0;
		if (st_ff.op != dspmc_pkg::MC_NONE) begin
			nxt_st.cnt = st_ff.cnt - 2'h1;
			if (st_ff.cnt == dspmc_pkg::CNT_LAST) begin
				nxt_st.op = dspmc_pkg::MC_NONE;
				nxt_st.ready = 1'b1;
				nxt_st.done = 1'b1;
				unique case (st_ff.op)
					dspmc_pkg::MC_PUSH: begin
						nxt_st.stk = {st_ff.stk[dspmc_pkg::STK_DEPTH-2:0],
							st_ff.acc[dspmc_pkg::DW-1:0]};
					end
					dspmc_pkg::MC_POP: begin
						nxt_st.acc = {dspmc_pkg::WORD_RST, st_ff.stk[0]};
						nxt_st.stk = {st_ff.stk[dspmc_pkg::STK_DEPTH-1],
							st_ff.stk[dspmc_pkg::STK_DEPTH-1:1]};
					end
					dspmc_pkg::MC_PORT_IN: begin
						nxt_st.dwr = '{1'b1, st_ff.daddr, port_rdata};
					end
					dspmc_pkg::MC_TBL_RD: begin
						nxt_st.dwr = '{1'b1, st_ff.daddr, pmem_rdata};
					end
					dspmc_pkg::MC_TBL_WR: begin
						nxt_st.pmem.we = 1'b1;
						nxt_st.pmem.wdata = st_ff.operand;
					end
					default: begin
						nxt_st.done = 1'b1;
					end
				endcase
			end
		end else if (accept) begin
			nxt_st.done = 1'b1;
			nxt_st.daddr = issue.daddr;
			nxt_st.operand = issue.operand;
			if (issue.instr == dspmc_pkg::OPC_ADD_PRODUCT) begin
				nxt_st.acc = st_ff.acc + st_ff.prod;
			end else if (issue.instr == dspmc_pkg::OPC_PRODUCT_TO_ACC) begin
				nxt_st.acc = st_ff.prod;
			end else if (issue.instr == dspmc_pkg::OPC_SUBTRACT_PRODUCT) begin
				nxt_st.acc = st_ff.acc - st_ff.prod;
			end else if (issue.instr == dspmc_pkg::OPC_PUSH ||
				issue.instr == dspmc_pkg::OPC_POP) begin
				nxt_st.op = (issue.instr == dspmc_pkg::OPC_PUSH) ?
					dspmc_pkg::MC_PUSH : dspmc_pkg::MC_POP;
				nxt_st.cnt = dspmc_pkg::CYC_STACK - 2'h1;
				nxt_st.ready = 1'b0;
				nxt_st.done = 1'b0;
			end else if (hi == dspmc_pkg::OPC_LOAD_MCAND) begin
				nxt_st.mcand = issue.operand;
			end else if (hi == dspmc_pkg::OPC_LOAD_MCAND_ACC ||
				hi == dspmc_pkg::OPC_LOAD_MCAND_ACC_MOVE) begin
				nxt_st.mcand = issue.operand;
				nxt_st.acc = st_ff.acc + st_ff.prod;
				if (hi == dspmc_pkg::OPC_LOAD_MCAND_ACC_MOVE) begin
					nxt_st.dwr = '{1'b1, issue.daddr + dspmc_pkg::DADDR_ONE,
						issue.operand};
				end
			end else if (hi == dspmc_pkg::OPC_MULTIPLY ||
				issue.instr[15:13] == dspmc_pkg::OPC_MULT_IMM) begin
				nxt_st.prod = mul_p;
			end else if (hi == dspmc_pkg::OPC_DATA_MOVE) begin
				nxt_st.dwr = '{1'b1, issue.daddr + dspmc_pkg::DADDR_ONE,
					issue.operand};
			end else if (issue.instr[15:11] == dspmc_pkg::OPC_PORT_IN) begin
				nxt_st.op = dspmc_pkg::MC_PORT_IN;
				nxt_st.cnt = dspmc_pkg::CYC_PORT_IN - 2'h1;
				nxt_st.ready = 1'b0;
				nxt_st.done = 1'b0;
				nxt_st.port = '{1'b1,
					issue.instr[dspmc_pkg::PORT_FIELD_MSB:dspmc_pkg::PORT_FIELD_LSB]};
			end else if (hi == dspmc_pkg::OPC_TABLE_READ ||
				hi == dspmc_pkg::OPC_TABLE_WRITE) begin
				nxt_st.op = (hi == dspmc_pkg::OPC_TABLE_READ) ?
					dspmc_pkg::MC_TBL_RD : dspmc_pkg::MC_TBL_WR;
				nxt_st.cnt = dspmc_pkg::CYC_TABLE - 2'h1;
				nxt_st.ready = 1'b0;
				nxt_st.done = 1'b0;
				nxt_st.pmem.re = (hi == dspmc_pkg::OPC_TABLE_READ);
				nxt_st.pmem.addr = st_ff.acc[dspmc_pkg::PAW-1:0];
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '0;
			st_ff.ready <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	//----------------------------------------------------------------
	// Outputs
	//----------------------------------------------------------------
	assign ready_ff = st_ff.ready;
	assign done_ff = st_ff.done;
	assign dwr_ff = st_ff.dwr;
	assign pmem_ff = st_ff.pmem;
	assign port_ff = st_ff.port;
	assign acc_ff = st_ff.acc;
	assign mcand_ff = st_ff.mcand;
	assign prod_ff = st_ff.prod;

	//----------------------------------------------------------------
	// Assertions
	//----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_take_stack;
		accept && (issue.instr == dspmc_pkg::OPC_POP ||
			issue.instr == dspmc_pkg::OPC_PUSH);
	endsequence
	sequence s_take_table;
		accept && (hi == dspmc_pkg::OPC_TABLE_READ ||
			hi == dspmc_pkg::OPC_TABLE_WRITE);
	endsequence

	property p_add_product;
		accept && issue.instr == dspmc_pkg::OPC_ADD_PRODUCT |=>
			acc_ff == $past(acc_ff) + $past(prod_ff) && done_ff && ready_ff;
	endproperty
	a_add_product: assert property (p_add_product)
		else $error("add-product result wrong");

	property p_load_mcand_acc;
		accept && hi == dspmc_pkg::OPC_LOAD_MCAND_ACC |=>
			mcand_ff == $past(issue.operand) &&
			acc_ff == $past(acc_ff) + $past(prod_ff);
	endproperty
	a_load_mcand_acc: assert property (p_load_mcand_acc)
		else $error("load-multiplicand-accumulate wrong");

	property p_load_mcand_acc_move;
		accept && hi == dspmc_pkg::OPC_LOAD_MCAND_ACC_MOVE |=>
			dwr_ff.we && dwr_ff.addr == $past(issue.daddr) + 8'h01 &&
			acc_ff == $past(acc_ff) + $past(prod_ff);
	endproperty
	a_load_mcand_acc_move: assert property (p_load_mcand_acc_move)
		else $error("accumulate-and-move wrong");

	property p_multiply;
		accept && hi == dspmc_pkg::OPC_MULTIPLY |=>
			$signed(prod_ff) ==
			$signed($past(mcand_ff)) * $signed($past(issue.operand));
	endproperty
	a_multiply: assert property (p_multiply)
		else $error("multiply product wrong");

	property p_subtract_product;
		accept && issue.instr == dspmc_pkg::OPC_SUBTRACT_PRODUCT |=>
			acc_ff == $past(acc_ff) - $past(prod_ff);
	endproperty
	a_subtract_product: assert property (p_subtract_product)
		else $error("subtract-product wrong");

	property p_stack;
		s_take_stack |=> !ready_ff && !done_ff ##1 ready_ff && done_ff;
	endproperty
	a_stack: assert property (p_stack)
		else $error("stack op not two cycles");

	property p_port_in;
		accept && issue.instr[15:11] == dspmc_pkg::OPC_PORT_IN |=>
			port_ff.re && !ready_ff ##1 dwr_ff.we && done_ff;
	endproperty
	a_port_in: assert property (p_port_in)
		else $error("port input not two cycles");

	property p_table;
		s_take_table |=> (!ready_ff && !done_ff)[*2] ##1
			(done_ff && (dwr_ff.we || pmem_ff.we));
	endproperty
	a_table: assert property (p_table)
		else $error("table op not three cycles");

	property p_move;
		accept && hi == dspmc_pkg::OPC_DATA_MOVE |=>
			dwr_ff.we && dwr_ff.data == $past(issue.operand) &&
			dwr_ff.addr == $past(issue.daddr) + 8'h01;
	endproperty
	a_move: assert property (p_move)
		else $error("data move wrong");

endmodule : dspmc_exec

// ==== inc/dspmc_pkg.sv ====
// Shared constants and carrier types for the multiply/stack/move execution unit
package dspmc_pkg;

	//--------------------------------------------------------------
	// Widths
	//--------------------------------------------------------------
	localparam int DW = 16;
	localparam int AW = 32;
	localparam int DAW = 8;
	localparam int PAW = 12;
	localparam int STK_DEPTH = 4;

	//--------------------------------------------------------------
	// Full-word opcodes
	//--------------------------------------------------------------
	localparam logic [15:0] OPC_ADD_PRODUCT = 16'h7f8f;
	localparam logic [15:0] OPC_PRODUCT_TO_ACC = 16'h7f8e;
	localparam logic [15:0] OPC_SUBTRACT_PRODUCT = 16'h7f90;
	localparam logic [15:0] OPC_POP = 16'h7f9d;
	localparam logic [15:0] OPC_PUSH = 16'h7f9c;

	//--------------------------------------------------------------
	// Upper-byte opcodes (bits 15:8), operand address below
	//--------------------------------------------------------------
	localparam logic [7:0] OPC_LOAD_MCAND = 8'h6a;
	localparam logic [7:0] OPC_LOAD_MCAND_ACC = 8'h6c;
	localparam logic [7:0] OPC_LOAD_MCAND_ACC_MOVE = 8'h6b;
	localparam logic [7:0] OPC_MULTIPLY = 8'h6d;
	localparam logic [7:0] OPC_DATA_MOVE = 8'h69;
	localparam logic [7:0] OPC_TABLE_READ = 8'h67;
	localparam logic [7:0] OPC_TABLE_WRITE = 8'h7d;

	// Short-field opcodes
	localparam logic [2:0] OPC_MULT_IMM = 3'h4;
	localparam logic [4:0] OPC_PORT_IN = 5'h08;
	localparam int IMM_MSB = 12;
	localparam int PORT_FIELD_MSB = 10;
	localparam int PORT_FIELD_LSB = 8;

	//--------------------------------------------------------------
	// Cycle counts
	//--------------------------------------------------------------
	localparam logic [1:0] CYC_STACK = 2'h2;
	localparam logic [1:0] CYC_PORT_IN = 2'h2;
	localparam logic [1:0] CYC_TABLE = 2'h3;
	localparam logic [1:0] CNT_LAST = 2'h1;

	// Reset values and data address step
	localparam logic [AW-1:0] ACC_RST = 32'h0000_0000;
	localparam logic [DW-1:0] WORD_RST = 16'h0000;
	localparam logic [DAW-1:0] DADDR_ONE = 8'h01;

	//--------------------------------------------------------------
	// Types
	//--------------------------------------------------------------
	typedef enum logic [2:0] {
		MC_NONE, MC_PUSH, MC_POP, MC_PORT_IN, MC_TBL_RD, MC_TBL_WR
	} dspmc_mcop_t;

	// Instruction with its direct operand already fetched
	typedef struct packed {
		logic valid;
		logic [DW-1:0] instr;
		logic [DW-1:0] operand;
		logic [DAW-1:0] daddr;
	} dspmc_issue_t;

	typedef struct packed {
		logic we;
		logic [DAW-1:0] addr;
		logic [DW-1:0] data;
	} dspmc_dwr_t;

	typedef struct packed {
		logic re;
		logic we;
		logic [PAW-1:0] addr;
		logic [DW-1:0] wdata;
	} dspmc_pmem_t;

	typedef struct packed {
		logic re;
		logic [2:0] sel;
	} dspmc_port_t;

endpackage : dspmc_pkg

// ==== core/dspmc_mult.sv ====
// Signed 16x16 multiplier feeding the product register
module dspmc_mult (
	// Operands
	input wire logic [dspmc_pkg::DW-1:0] mcand,
	input wire logic [dspmc_pkg::DW-1:0] mplier,
	// Result
	output logic [dspmc_pkg::AW-1:0] product
);

	// Both operands two's complement, full-width product
	always_comb begin
		product = $signed(mcand) * $signed(mplier);
	end

endmodule : dspmc_mult

// ==== verif/dspmc_far.sv ====
// Program memory and I/O port model facing the execution unit
module dspmc_far (
	// Clock
	input wire logic clk,
	// Requests from the unit
	input wire dspmc_pkg::dspmc_pmem_t pmem,
	input wire dspmc_pkg::dspmc_port_t port,
	// Answers
	output logic [15:0] pmem_rdata,
	output logic [15:0] port_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [4096];
	logic rd_hold = 1'b0;
	// Contents follow a fixed pattern
	initial begin
		for (int i = 0; i < 4096; i++) mem[i] = 16'(i) ^ 16'h5a5a;
	end
	// Write lands on its strobe; read data stays one cycle longer
	always @(posedge clk) begin
		if (pmem.we) mem[pmem.addr] <= pmem.wdata;
		rd_hold <= pmem.re;
	end
	// Outside a read the lines show the inverse, never stale data
	assign pmem_rdata = (pmem.re || rd_hold) ?
		mem[pmem.addr] : ~mem[pmem.addr];
	assign port_rdata = port.re ?
		16'hc0f0 + port.sel : ~(16'hc0f0 + port.sel);
endmodule : dspmc_far

// ==== verif/dsp_multiply_control_io_ops_tb.sv ====
// Self-checking bench for the execution unit with a reference model
module dsp_multiply_control_io_ops_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	dspmc_pkg::dspmc_issue_t issue = '0;
	logic ready_ff, done_ff;
	dspmc_pkg::dspmc_dwr_t dwr_ff;
	dspmc_pkg::dspmc_pmem_t pmem_ff;
	dspmc_pkg::dspmc_port_t port_ff;
	logic [15:0] pmem_rdata, port_rdata, mcand_ff;
	logic [31:0] acc_ff, prod_ff;
	int n_errors = 0;
	int n_compared = 0;
	// Reference state
	logic [31:0] m_acc = '0;
	logic [31:0] m_prod = '0;
	logic [15:0] m_mc = '0;
	logic [15:0] m_stk [$] = '{16'h0, 16'h0, 16'h0, 16'h0};
	logic [15:0] m_pm [4096];
	logic [15:0] ops [15] = '{16'h7f8f, 16'h7f8e, 16'h7f90, 16'h7f9c,
		16'h7f9d, 16'h6a00, 16'h6c00, 16'h6b00, 16'h6d00, 16'h8000,
		16'h4000, 16'h6900, 16'h6700, 16'h7d00, 16'hf000};

	// Clock at 100 ns period
	always #50 clk = ~clk;

	dspmc_exec u_dspmc_exec (.clk(clk), .rstn(rstn), .issue(issue),
		.ready_ff(ready_ff), .done_ff(done_ff), .dwr_ff(dwr_ff),
		.pmem_rdata(pmem_rdata), .pmem_ff(pmem_ff),
		.port_rdata(port_rdata), .port_ff(port_ff), .acc_ff(acc_ff),
		.mcand_ff(mcand_ff), .prod_ff(prod_ff));
	dspmc_far u_dspmc_far (.clk(clk), .pmem(pmem_ff), .port(port_ff),
		.pmem_rdata(pmem_rdata), .port_rdata(port_rdata));

	// Compare one value and count it
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		n_compared++;
		if (e !== s) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// Print counts and verdict, then stop
	task automatic final_report();
		$display("Compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	// Issue one instruction, update the model, check the result
	task automatic run(logic [15:0] ins, logic [15:0] opd, logic [7:0] da);
		int cyc, n, sa, sb;
		logic dwe, pwe;
		logic [15:0] dd;
		logic [7:0] dadr;
		cyc = 1;
		dwe = 1'b0;
		pwe = 1'b0;
		dd = opd;
		dadr = da + 8'h01;
		sa = $signed(m_mc);
		sb = $signed(opd);
		if (ins == dspmc_pkg::OPC_ADD_PRODUCT) m_acc += m_prod;
		else if (ins == dspmc_pkg::OPC_PRODUCT_TO_ACC) m_acc = m_prod;
		else if (ins == dspmc_pkg::OPC_SUBTRACT_PRODUCT) m_acc -= m_prod;
		else if (ins == dspmc_pkg::OPC_PUSH) begin
			cyc = 2;
			m_stk.push_front(m_acc[15:0]);
			void'(m_stk.pop_back());
		end else if (ins == dspmc_pkg::OPC_POP) begin
			cyc = 2;
			m_acc = {16'h0, m_stk.pop_front()};
			m_stk.push_back(m_stk[$]);
		end else if (ins[15:13] == dspmc_pkg::OPC_MULT_IMM) begin
			sb = $signed(ins[12:0]);
			m_prod = sa * sb;
		end else if (ins[15:11] == dspmc_pkg::OPC_PORT_IN) begin
			cyc = 2;
			dwe = 1'b1;
			dadr = da;
			dd = 16'hc0f0 + ins[10:8];
		end else case (ins[15:8])
			dspmc_pkg::OPC_LOAD_MCAND: m_mc = opd;
			dspmc_pkg::OPC_LOAD_MCAND_ACC: begin
				m_acc += m_prod;
				m_mc = opd;
			end
			dspmc_pkg::OPC_LOAD_MCAND_ACC_MOVE: begin
				m_acc += m_prod;
				m_mc = opd;
				dwe = 1'b1;
			end
			dspmc_pkg::OPC_MULTIPLY: m_prod = sa * sb;
			dspmc_pkg::OPC_DATA_MOVE: dwe = 1'b1;
			dspmc_pkg::OPC_TABLE_READ: begin
				cyc = 3;
				dwe = 1'b1;
				dadr = da;
				dd = m_pm[m_acc[11:0]];
			end
			dspmc_pkg::OPC_TABLE_WRITE: begin
				cyc = 3;
				pwe = 1'b1;
				m_pm[m_acc[11:0]] = opd;
			end
			default: ;
		endcase
		issue = '{1'b1, ins, opd, da};
		@(negedge clk);
		n = 1;
		// Junk offered while busy must be ignored
		while (done_ff !== 1'b1 && n < 8) begin
			issue.instr = 16'($urandom);
			@(negedge clk);
			n++;
		end
		chk("cycles", cyc, n);
		chk("ready", 1, ready_ff);
		chk("acc", m_acc, acc_ff);
		chk("mcand", m_mc, mcand_ff);
		chk("prod", m_prod, prod_ff);
		chk("dwe", dwe, dwr_ff.we);
		if (dwe) chk("daddr", dadr, dwr_ff.addr);
		if (dwe) chk("ddata", dd, dwr_ff.data);
		chk("pwe", pwe, pmem_ff.we);
		if (pwe) chk("pdata", opd, pmem_ff.wdata);
		if (pwe) chk("paddr", m_acc[11:0], pmem_ff.addr);
	endtask : run

	// Main sequence: reset, signed corners, then random traffic
	initial begin
		int k;
		logic [15:0] r;
		logic [15:0] ins;
		void'($urandom(14338));
		for (int i = 0; i < 4096; i++) m_pm[i] = 16'(i) ^ 16'h5a5a;
		repeat (20) @(negedge clk);
		chk("ready", 1, ready_ff);
		chk("acc0", 0, acc_ff);
		rstn = 1'b1;
		@(negedge clk);
		run(16'h6a00, 16'h8000, 8'h10);
		run(16'h6d00, 16'h8000, 8'h11);
		run(16'h7f8e, 16'h0, 8'h0);
		run(16'h9fff, 16'h0, 8'h0);
		run(16'h6bff, 16'h1234, 8'hff);
		for (int j = 0; j < 300; j++) begin
			k = $urandom_range(14);
			r = 16'($urandom);
			ins = ops[k];
			if (k == 9) ins[12:0] = r[12:0];
			else if (k == 10) ins[10:0] = r[10:0];
			else if (ins[7:0] == 8'h00) ins[7:0] = r[7:0];
			run(ins, 16'($urandom), 8'($urandom));
		end
		// Nothing may happen while no instruction is offered
		issue.valid = 1'b0;
		repeat (2) @(negedge clk);
		chk("idle done", 0, done_ff);
		chk("idle acc", m_acc, acc_ff);
		final_report();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#500000;
		n_errors++;
		final_report();
	end
endmodule : dsp_multiply_control_io_ops_tb
